// *** design/fsj_top.v ***
// Feed-step status encoder and manual jog front end with AHB-Lite registers.
// Assumes drive-state inputs come from logic on clk; mode pins are asynchronous.
//
// The placing of the registers and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
`include "fsj_defines.vh"
module fsj_top #(
  parameter HOLD_TICK_CYC = `FSJ_HOLD_UNIT_NS / `FSJ_CLK_NS
) (
  input wire clk,
  input wire rstn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire mode_input_low,
  input wire mode_input_high,
  input wire manual_continuous_select,
  input wire manual_single_step_select,
  input wire servo_on_in,
  input wire home_sensor_in,
  input wire [4:0] feed_step_select_inputs,
  input wire alarm_in,
  input wire drive_ready_in,
  input wire homing_busy_in,
  input wire home_done_in,
  input wire move_busy_in,
  input wire in_position_in,
  input wire [4:0] reached_index_in,
  output wire status_out_bit0,
  output wire status_out_bit1,
  output wire status_out_bit2,
  output wire status_out_bit3,
  output wire status_out_bit4,
  output reg servo_on_out,
  output reg home_sensor_out,
  output reg [4:0] index_select_out,
  output wire feed_step_mode,
  output wire homing_mode,
  output wire torque_decrease,
  output wire emergency_stop,
  output reg jog_fwd_step,
  output reg jog_rev_step,
  output reg jog_fwd_run,
  output reg jog_rev_run,
  output reg [15:0] jog_speed
);
  // Mode states, one-hot
  localparam [4:0] ST_TQD = 5'h01;
  localparam [4:0] ST_FEED = 5'h02;
  localparam [4:0] ST_HOME = 5'h04;
  localparam [4:0] ST_MAN = 5'h08;
  localparam [4:0] ST_ESTOP = 5'h10;

  reg rst_meta_r;
  reg rst_sync_r;
  wire rst_n;
  wire [10:0] pins_s;
  reg [7:0] src_r;
  reg [7:0] swin_r;
  reg [1:0] cfg_r;
  reg [15:0] spd1_r;
  reg [15:0] spd2_r;
  reg [15:0] hold_r;
  reg [15:0] hold_cnt_r;
  reg [15:0] hold_cnt_nxt;
  reg [4:0] code_r;
  reg [4:0] code_nxt;
  reg [4:0] state_r;
  reg [4:0] state_nxt;
  reg mode_lo_prev_r;
  reg mode_hi_prev_r;
  reg inpos_prev_r;
  reg wr_pend_r;
  reg [11:0] wr_idx_r;
  wire sw_src;
  wire mode_lo;
  wire mode_hi;
  wire man_cont;
  wire man_single;
  wire inpos_rise;
  wire hold_load;
  wire hold_tick;
  wire addr_phase;
  wire [11:0] a_idx;

  // Reset: asynchronous assert, release through two flops
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  assign rst_n = rst_sync_r;

  // Pin levels cross into clk before any logic sees them
  fsj_sync #(.W(11)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({mode_input_low, mode_input_high, manual_continuous_select,
        manual_single_step_select, servo_on_in, home_sensor_in,
        feed_step_select_inputs}),
    .q_r(pins_s)
  );

  // Software takes over the input set only on the exact key
  assign sw_src = (src_r == `FSJ_SW_KEY);
  assign mode_lo = sw_src ? swin_r[`FSJ_SW_MODE_LO] : pins_s[10];
  assign mode_hi = sw_src ? swin_r[`FSJ_SW_MODE_HI] : pins_s[9];
  // Manual selects have no software image, so they stay on the pins
  assign man_cont = pins_s[8];
  assign man_single = pins_s[7];

  // Emulated servo on, home sensor and index lines
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      servo_on_out <= 1'b0;
      home_sensor_out <= 1'b0;
      index_select_out <= 5'h00;
    end else if (sw_src) begin
      servo_on_out <= swin_r[`FSJ_SW_SERVO];
      home_sensor_out <= swin_r[`FSJ_SW_HSENS];
      index_select_out <= swin_r[4:0];
    end else begin
      servo_on_out <= pins_s[6];
      home_sensor_out <= pins_s[5];
      index_select_out <= pins_s[4:0];
    end
  end

  // Mode machine; a direct feed/homing swap lands in emergency stop
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_TQD: begin
        if (mode_lo && mode_hi) state_nxt = ST_ESTOP;
        else if (man_cont || man_single) state_nxt = ST_MAN;
        else if (mode_lo) state_nxt = ST_FEED;
        else if (mode_hi) state_nxt = ST_HOME;
      end
      ST_FEED: begin
        if (mode_hi) state_nxt = ST_ESTOP;
        else if (!mode_lo) state_nxt = ST_TQD;
      end
      ST_HOME: begin
        if (mode_lo) state_nxt = ST_ESTOP;
        else if (!mode_hi) state_nxt = ST_TQD;
      end
      ST_MAN: begin
        if (mode_lo && mode_hi) state_nxt = ST_ESTOP;
        else if (!man_cont && !man_single) state_nxt = ST_TQD;
      end
      ST_ESTOP: begin
        // Warning clears once both mode inputs are released
        if (!mode_lo && !mode_hi) state_nxt = ST_TQD;
      end
      default: state_nxt = ST_TQD;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) state_r <= ST_TQD;
    else state_r <= state_nxt;
  end

  assign torque_decrease = state_r[0];
  assign feed_step_mode = state_r[1];
  assign homing_mode = state_r[2];
  assign emergency_stop = state_r[4];

  // Jog outputs; single step wins when both manual selects are on
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_lo_prev_r <= 1'b0;
      mode_hi_prev_r <= 1'b0;
      jog_fwd_step <= 1'b0;
      jog_rev_step <= 1'b0;
      jog_fwd_run <= 1'b0;
      jog_rev_run <= 1'b0;
      jog_speed <= `FSJ_RST_HALF;
    end else begin
      mode_lo_prev_r <= mode_lo;
      mode_hi_prev_r <= mode_hi;
      jog_fwd_step <= state_r[3] && man_single && mode_lo && !mode_lo_prev_r && !mode_hi;
      jog_rev_step <= state_r[3] && man_single && mode_hi && !mode_hi_prev_r && !mode_lo;
      jog_fwd_run <= state_r[3] && !man_single && man_cont && mode_lo && !mode_hi;
      jog_rev_run <= state_r[3] && !man_single && man_cont && mode_hi && !mode_lo;
      if (man_single && !cfg_r[`FSJ_CFG_VAR2]) jog_speed <= spd1_r;
      else jog_speed <= spd2_r;
    end
  end

  // Hold counter paced by the 4 ms unit tick
  assign inpos_rise = in_position_in && !inpos_prev_r;
  assign hold_load = inpos_rise && cfg_r[`FSJ_CFG_COMB] && !alarm_in;

  fsj_tick #(.CYC(HOLD_TICK_CYC)) u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .restart(hold_load),
    .tick_r(hold_tick)
  );

  always @* begin
    hold_cnt_nxt = hold_cnt_r;
    if (!cfg_r[`FSJ_CFG_COMB] || alarm_in) hold_cnt_nxt = 16'h0000;
    else if (hold_load) hold_cnt_nxt = hold_r;
    else if (hold_tick && hold_cnt_r != 16'h0000) hold_cnt_nxt = hold_cnt_r - 16'h0001;
  end

  // Status code by priority; alarm overrides any hold
  always @* begin
    code_nxt = `FSJ_CODE_FAULT;
    if (alarm_in) code_nxt = `FSJ_CODE_FAULT;
    else if (hold_cnt_r != 16'h0000) code_nxt = code_r;
    else if (homing_busy_in) code_nxt = `FSJ_CODE_HOMING;
    else if (home_done_in) code_nxt = `FSJ_CODE_HOMED;
    else if (move_busy_in) code_nxt = `FSJ_CODE_MOVING;
    else if (in_position_in && reached_index_in >= `FSJ_INDEX_MIN &&
             reached_index_in <= `FSJ_INDEX_MAX)
      code_nxt = reached_index_in + `FSJ_INPOS_OFS;
    else if (drive_ready_in) code_nxt = `FSJ_CODE_READY;
  end

  // One register drives all five outputs, so no mixed code appears
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_r <= `FSJ_CODE_FAULT;
      hold_cnt_r <= 16'h0000;
      inpos_prev_r <= 1'b0;
    end else begin
      code_r <= code_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      inpos_prev_r <= in_position_in;
    end
  end

  // Bit 4 is the most significant output
  assign status_out_bit0 = code_r[0];
  assign status_out_bit1 = code_r[1];
  assign status_out_bit2 = code_r[2];
  assign status_out_bit3 = code_r[3];
  assign status_out_bit4 = code_r[4];

  // Bus slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = `FSJ_HRESP_OKAY;
  assign addr_phase = hsel && htrans[`FSJ_HTRANS_NONSEQ_BIT] && hready;
  assign a_idx = haddr[13:2];

  function [31:0] read_word;
    input [11:0] idx;
    begin
      case (idx)
        `FSJ_IDX_SRC: read_word = {24'h000000, src_r};
        `FSJ_IDX_SWIN: read_word = {24'h000000, swin_r};
        `FSJ_IDX_CFG: read_word = {30'h00000000, cfg_r};
        `FSJ_IDX_SPD1: read_word = {16'h0000, spd1_r};
        `FSJ_IDX_SPD2: read_word = {16'h0000, spd2_r};
        `FSJ_IDX_HOLD: read_word = {16'h0000, hold_r};
        `FSJ_IDX_STAT: read_word = {16'h0000, hold_cnt_r != 16'h0000, 2'h0,
                                    state_r, 3'h0, code_r};
        default: read_word = 32'h00000000;
      endcase
    end
  endfunction

  // Read data is sampled at the address phase, written at the data phase
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
      wr_pend_r <= 1'b0;
      wr_idx_r <= 12'h000;
    end else begin
      wr_pend_r <= addr_phase && hwrite;
      if (addr_phase) wr_idx_r <= a_idx;
      if (addr_phase && !hwrite) hrdata <= read_word(a_idx);
    end
  end

  // Register writes; unmapped writes are dropped
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_r <= `FSJ_RST_BYTE;
      swin_r <= `FSJ_RST_BYTE;
      cfg_r <= `FSJ_RST_CFG;
      spd1_r <= `FSJ_RST_HALF;
      spd2_r <= `FSJ_RST_HALF;
      hold_r <= `FSJ_RST_HALF;
    end else if (wr_pend_r) begin
      case (wr_idx_r)
        `FSJ_IDX_SRC: src_r <= hwdata[7:0];
        `FSJ_IDX_SWIN: swin_r <= hwdata[7:0];
        `FSJ_IDX_CFG: cfg_r <= hwdata[1:0];
        `FSJ_IDX_SPD1: spd1_r <= hwdata[15:0];
        `FSJ_IDX_SPD2: spd2_r <= hwdata[15:0];
        `FSJ_IDX_HOLD: hold_r <= hwdata[15:0];
        default: src_r <= src_r;
      endcase
    end
  end
endmodule // fsj_top

// *** shared/fsj_defines.vh ***
// Constants for the feed-step status and jog control block.
// Included by the top design file; holds definitions only.
`ifndef FSJ_DEFINES_VH
`define FSJ_DEFINES_VH

// Register indices; the byte address is four times the index
`define FSJ_IDX_SRC 12'h306
`define FSJ_IDX_SWIN 12'h407
`define FSJ_IDX_CFG 12'h010
`define FSJ_IDX_SPD1 12'h011
`define FSJ_IDX_SPD2 12'h012
`define FSJ_IDX_HOLD 12'h013
`define FSJ_IDX_STAT 12'h014
`define FSJ_IDX_W 12

// Register values and field positions
`define FSJ_SW_KEY 8'hFF
`define FSJ_SW_MODE_LO 7
`define FSJ_SW_MODE_HI 6
`define FSJ_SW_SERVO 5
`define FSJ_SW_HSENS 4
`define FSJ_CFG_COMB 0
`define FSJ_CFG_VAR2 1
`define FSJ_RST_BYTE 8'h00
`define FSJ_RST_HALF 16'h0000
`define FSJ_RST_CFG 2'h0

// Status output codes
`define FSJ_CODE_FAULT 5'h00
`define FSJ_CODE_READY 5'h01
`define FSJ_CODE_HOMING 5'h02
`define FSJ_CODE_HOMED 5'h03
`define FSJ_CODE_MOVING 5'h04
`define FSJ_INPOS_OFS 5'h04
`define FSJ_INDEX_MIN 5'h01
`define FSJ_INDEX_MAX 5'h1B

// Timing: hold delay unit and clock period, both in ns
`define FSJ_HOLD_UNIT_NS 4000000
`define FSJ_CLK_NS 8

// AHB-Lite encodings
`define FSJ_HTRANS_NONSEQ_BIT 1
`define FSJ_HRESP_OKAY 1'b0

`endif

// *** design/fsj_sync.v ***
// Two-flop synchroniser for a group of pin levels.
// Assumes the levels are quasi-static with respect to clk.
`timescale 1ns/10ps
module fsj_sync #(
  parameter W = 1
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] d,
  output reg [W-1:0] q_r
);
  reg [W-1:0] meta_r;

  // First stage feeds only the second stage
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= {W{1'b0}};
      q_r <= {W{1'b0}};
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end
endmodule // fsj_sync

// *** design/fsj_tick.v ***
// Divider giving one enable pulse per hold delay unit.
// Assumes a single clock; restart realigns the unit to a new hold.
`timescale 1ns/10ps
module fsj_tick #(
  parameter CYC = 500000
) (
  input wire clk,
  input wire rst_n,
  input wire restart,
  output reg tick_r
);
  reg [31:0] cnt_r;

  // Restart keeps the first unit a whole unit long
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 32'h00000000;
      tick_r <= 1'b0;
    end else if (restart) begin
      cnt_r <= 32'h00000000;
      tick_r <= 1'b0;
    end else if (cnt_r == CYC - 1) begin
      cnt_r <= 32'h00000000;
      tick_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h00000001;
      tick_r <= 1'b0;
    end
  end
endmodule // fsj_tick

// *** test/fsj_top_checker.sv ***
// Assertions on the status code, jog outputs and emergency stop of fsj_top.
// Sees the top ports only; bound into every fsj_top below.
`timescale 1ns/10ps
module fsj_top_checker (
  input wire clk,
  input wire rstn,
  input wire mode_input_low,
  input wire mode_input_high,
  input wire manual_continuous_select,
  input wire manual_single_step_select,
  input wire alarm_in,
  input wire drive_ready_in,
  input wire homing_busy_in,
  input wire home_done_in,
  input wire move_busy_in,
  input wire in_position_in,
  input wire [4:0] reached_index_in,
  input wire status_out_bit0,
  input wire status_out_bit1,
  input wire status_out_bit2,
  input wire status_out_bit3,
  input wire status_out_bit4,
  input wire emergency_stop,
  input wire jog_fwd_step,
  input wire jog_fwd_run
);
  reg [1:0] up_r;
  // Quiet until the two-flop reset copy has let go
  wire live = rstn && (up_r == 2'h3);
  wire [4:0] code = {status_out_bit4, status_out_bit3, status_out_bit2,
    status_out_bit1, status_out_bit0};
  wire idle = !alarm_in && !homing_busy_in && !home_done_in && !move_busy_in;
  wire idx_ok = (reached_index_in >= 5'h01) && (reached_index_in <= 5'h1B);
  wire msel = manual_single_step_select && !manual_continuous_select;
  // Cycles since reset release, saturating
  always @(posedge clk or negedge rstn) begin
    if (!rstn) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!live);
  alarm_zero_a: assert property (alarm_in |=> code == 5'h00)
    else $error("alarm code wrong");
  // Stable escape covers a combination hold still running
  ready_code_a: assert property (idle && drive_ready_in && !(in_position_in && idx_ok)
    |=> (code == 5'h01) || $stable(code)) else $error("ready code wrong");
  homing_code_a: assert property (!alarm_in && homing_busy_in |=> code == 5'h02)
    else $error("homing code wrong");
  homed_code_a: assert property (!alarm_in && !homing_busy_in && home_done_in
    |=> code == 5'h03) else $error("homed code wrong");
  moving_code_a: assert property (idle || move_busy_in && !alarm_in && !homing_busy_in
    && !home_done_in |-> !move_busy_in or (##1 code == 5'h04)) else $error("move code");
  inpos_code_a: assert property (idle && in_position_in && idx_ok
    |=> code == $past(reached_index_in) + 5'h04) else $error("in position code");
  fwd_step_a: assert property (msel [*6] ##0 ($rose(mode_input_low) && !mode_input_high)
    |-> ##[1:5] jog_fwd_step) else $error("no forward step");
  fwd_run_a: assert property ((manual_continuous_select && !manual_single_step_select
    && mode_input_low && !mode_input_high) [*6] |-> jog_fwd_run) else $error("no run");
  both_stop_a: assert property ((mode_input_low && mode_input_high) [*5]
    |-> emergency_stop) else $error("no emergency stop");
endmodule // fsj_top_checker
bind fsj_top fsj_top_checker fsj_top_checker_i (.clk(clk), .rstn(rstn),
  .mode_input_low(mode_input_low), .mode_input_high(mode_input_high),
  .manual_continuous_select(manual_continuous_select),
  .manual_single_step_select(manual_single_step_select), .alarm_in(alarm_in),
  .drive_ready_in(drive_ready_in), .homing_busy_in(homing_busy_in),
  .home_done_in(home_done_in), .move_busy_in(move_busy_in), .in_position_in(in_position_in),
  .reached_index_in(reached_index_in), .status_out_bit0(status_out_bit0),
  .status_out_bit1(status_out_bit1), .status_out_bit2(status_out_bit2),
  .status_out_bit3(status_out_bit3), .status_out_bit4(status_out_bit4),
  .emergency_stop(emergency_stop), .jog_fwd_step(jog_fwd_step), .jog_fwd_run(jog_fwd_run));

// *** test/fsj_host.sv ***
// Host controller model: drives the mode pins, decodes the status code.
// Assumes the bench sequences its requests; pins move just after an edge.
`timescale 1ns/10ps
module fsj_host (
  input wire clk,
  input wire fwd_req,
  input wire rev_req,
  input wire [4:0] status,
  output logic mode_low = 1'b0,
  output logic mode_high = 1'b0,
  output wire [4:0] code,
  output wire [4:0] pos
);
  // Bench drops both requests before any select, both high to force a stop
  always @(posedge clk) begin
    mode_low <= fwd_req;
    mode_high <= rev_req;
  end
  // Five lines read as one binary word, bit4 weightiest
  assign code = status;
  assign pos = (code >= 5'h05) ? code - 5'h04 : 5'h00;
endmodule // fsj_host

// *** test/test_feed_step_status_and_jog_control.sv ***
// Self-checking bench for the feed-step status and jog block.
// Assumes fsj_top with a 10-cycle hold tick and the host model beside it.
`timescale 1ns/10ps
module test_feed_step_status_and_jog_control;
  logic clk, rstn, hsel, hwrite, sel_c, sel_s, fwd, rev, son, home;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, rd;
  logic [5:0] dst;
  logic [4:0] idx, fsel;
  wire hrdy, mlo, mhi, s_on, h_on, fmode, tqd, estop, jfs, jrs, frun, rrun, hmode, hrsp;
  wire [4:0] st, isel, code, pos;
  wire [15:0] spd;
  wire [31:0] hrdata;
  int error_cnt = 0, checked = 0, nf = 0, nr = 0;
  // Rows: drive state {alarm,ready,homing,done,move,inpos}, index, code
  // Last rows: alarm cuts homing, code falls back to ready, host homes again
  logic [15:0] rows [14] = '{16'hFC60, 16'h4001, 16'h6002, 16'h5003, 16'h4C44,
    16'h4425, 16'h077F, 16'h4401, 16'h3002, 16'h6002, 16'hE000, 16'h4001,
    16'h6002, 16'h0000};
  fsj_top #(.HOLD_TICK_CYC(10)) fsj_top_i (.clk(clk), .rstn(rstn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hrdy), .hreadyout(hrdy), .hresp(hrsp), .hrdata(hrdata), .mode_input_low(mlo),
    .mode_input_high(mhi), .manual_continuous_select(sel_c),
    .manual_single_step_select(sel_s), .servo_on_in(son), .home_sensor_in(home),
    .feed_step_select_inputs(fsel), .alarm_in(dst[5]), .drive_ready_in(dst[4]),
    .homing_busy_in(dst[3]), .home_done_in(dst[2]), .move_busy_in(dst[1]),
    .in_position_in(dst[0]), .reached_index_in(idx), .status_out_bit0(st[0]),
    .status_out_bit1(st[1]), .status_out_bit2(st[2]), .status_out_bit3(st[3]),
    .status_out_bit4(st[4]), .servo_on_out(s_on), .home_sensor_out(h_on),
    .index_select_out(isel), .feed_step_mode(fmode), .homing_mode(hmode),
    .torque_decrease(tqd), .emergency_stop(estop), .jog_fwd_step(jfs),
    .jog_rev_step(jrs), .jog_fwd_run(frun), .jog_rev_run(rrun), .jog_speed(spd));
  fsj_host fsj_host_i (.clk(clk), .fwd_req(fwd), .rev_req(rev), .status(st),
    .mode_low(mlo), .mode_high(mhi), .code(code), .pos(pos));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %0h want %0h", $time, got, exp);
    end
  endtask
  // One single AHB-Lite transfer; the slave paces both phases
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Step pulses counted so a doubled pulse shows
  always @(posedge clk) begin
    nf <= nf + jfs;
    nr <= nr + jrs;
  end
  initial begin
    #200000;
    error_cnt++;
    end_sim;
  end
  initial begin
    {rstn, hsel, hwrite, sel_c, sel_s, fwd, rev, son, home, htrans} = '0;
    {haddr, hwdata, dst, idx, fsel} = '0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (rows[i]) begin
      dst <= rows[i][15:10];
      idx <= rows[i][9:5];
      repeat (2) @(posedge clk);
      chk(code, rows[i][4:0]);
    end
    bus(1'b0, 32'h80, 32'h0);
    chk(rd, 32'h0);
    // Status word: idle torque decrease state, code zero, no hold
    bus(1'b0, 32'h50, 32'h0);
    chk(rd, 32'h100);
    chk(hrsp, 0);
    // Single-step jog, both variants of speed
    bus(1'b1, 32'h44, 32'h1234);
    bus(1'b1, 32'h48, 32'h5678);
    sel_s <= 1'b1;
    repeat (6) @(posedge clk);
    chk(spd, 32'h1234);
    // Variant one steps on either input; second input driven first, index lines untouched
    rev <= 1'b1;
    repeat (6) @(posedge clk);
    rev <= 1'b0;
    repeat (3) @(posedge clk);
    fwd <= 1'b1;
    repeat (6) @(posedge clk);
    fwd <= 1'b0;
    repeat (4) @(posedge clk);
    chk(nf, 1);
    chk(nr, 1);
    bus(1'b1, 32'h40, 32'h2);
    repeat (2) @(posedge clk);
    chk(spd, 32'h5678);
    sel_s <= 1'b0;
    repeat (5) @(posedge clk);
    chk(tqd, 1);
    // Continuous jog in both directions
    sel_c <= 1'b1;
    repeat (5) @(posedge clk);
    fwd <= 1'b1;
    repeat (8) @(posedge clk);
    chk(frun, 1);
    fwd <= 1'b0;
    rev <= 1'b1;
    repeat (8) @(posedge clk);
    chk(rrun, 1);
    chk(spd, 32'h5678);
    rev <= 1'b0;
    repeat (3) @(posedge clk);
    sel_c <= 1'b0;
    repeat (5) @(posedge clk);
    fwd <= 1'b1;
    rev <= 1'b1;
    repeat (6) @(posedge clk);
    chk(estop, 1);
    fwd <= 1'b0;
    rev <= 1'b0;
    repeat (6) @(posedge clk);
    chk(tqd, 1);
    // Software image ignored until the key is written
    bus(1'b1, 32'h101C, 32'h20);
    repeat (3) @(posedge clk);
    chk(s_on, 0);
    bus(1'b1, 32'hC18, 32'hFF);
    bus(1'b1, 32'h101C, 32'h70);
    repeat (3) @(posedge clk);
    chk({hmode, s_on, h_on}, 3'h7);
    // Torque decrease between homing and feed step avoids the stop
    bus(1'b1, 32'h101C, 32'h20);
    repeat (3) @(posedge clk);
    chk(tqd, 1);
    bus(1'b1, 32'h101C, 32'hA3);
    repeat (3) @(posedge clk);
    chk({fmode, isel}, 6'h23);
    bus(1'b1, 32'h101C, 32'h23);
    repeat (3) @(posedge clk);
    chk(tqd, 1);
    bus(1'b1, 32'hC18, 32'h0);
    repeat (3) @(posedge clk);
    chk(s_on, 0);
    // Combination hold of two units, ten cycles each
    dst <= 6'h10;
    bus(1'b1, 32'h4C, 32'h2);
    bus(1'b1, 32'h40, 32'h1);
    dst <= 6'h11;
    idx <= 5'h05;
    repeat (2) @(posedge clk);
    chk(code, 9);
    dst <= 6'h10;
    repeat (8) @(posedge clk);
    chk(code, 9);
    chk(pos, 5);
    repeat (25) @(posedge clk);
    chk(code, 1);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    chk({code, tqd, spd}, 22'h010000);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    chk(code, 1);
    end_sim;
  end
endmodule // test_feed_step_status_and_jog_control
